// ===== hw/col_fix_pkg.sv
package col_fix_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS       = 8'h00;
	localparam logic [7:0] STATE_OFS      = 8'h04;
	localparam logic [7:0] COL_INDEX_OFS  = 8'h08;
	localparam logic [7:0] GAIN_OFS       = 8'h0C;
	localparam logic [7:0] OFFSET_OFS     = 8'h10;
	localparam logic [7:0] STEP_OFS       = 8'h14;
	localparam logic [7:0] CMD_OFS        = 8'h18;
	localparam logic [7:0] IRQ_STAT_OFS   = 8'h1C;
	localparam logic [7:0] IRQ_MASK_OFS   = 8'h20;
	// Control fields
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_MODE_LSB = 1;
	// Command fields
	localparam int CMD_RESET_BIT = 0;
	localparam int CMD_SAVE_BIT  = 1;
	// Interrupt bits
	localparam int IRQ_FRAME_BIT = 0;
	localparam int IRQ_ERR_BIT   = 1;
	localparam int IRQ_SAVE_BIT  = 2;
	localparam int IRQ_W         = 3;
	// Reset values
	localparam logic        EN_RST       = 1'b1;
	localparam logic [15:0] GAIN_UNITY   = 16'h1000;
	localparam logic [15:0] OFFSET_NONE  = 16'h0000;
	localparam int          GAIN_FRAC    = 12;
	// Offset write granularity
	localparam int          STEP_LOG     = 5;
	localparam logic [15:0] OFFSET_STEP  = 16'h0020;
	// Correction modes
	typedef enum logic [1:0] {
		MODE_FACTORY = 2'h0,
		MODE_USER    = 2'h1,
		MODE_CALIB   = 2'h2
	} corr_mode_t;
endpackage

// ===== hw/column_shading_fix.sv
// Function
// - Output equals gain times the sum of pixel and offset
// - Coefficients picked by column index, plus gain level for factory
// - Correction enabled after reset
// - Three modes, factory after reset
// - Factory coefficients follow camera gain level
// - User mode uses one gain-independent set
// - Default user coefficients leave pixels unchanged
// - User table writable only in calibration
// - Calibration opens table, forces correction off
// - Calibration edits apply whenever the latched mode is user
// - Column index selects table entry, no row
// - Delta gain stored per column, readable in calibration
// - 16-bit delta offset stored per column
// - Offset step readable, off-step writes rejected
// - Table reset restores saved or defaults
// - Table save copies to retained storage
`timescale 1ns/1ps
module column_shading_fix
	import col_fix_pkg::*;
#(
	parameter int PIX_W = 12,
	parameter int COL_W = 6,
	parameter int LVL_W = 3
)(
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_b_i,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// Interrupt
	output logic                  irq_o,
	// Camera gain level for factory set choice
	input  wire logic [LVL_W-1:0] gain_level_i,
	// Factory coefficient lookup
	output logic      [COL_W-1:0] fac_col_o,
	output logic      [LVL_W-1:0] fac_level_o,
	input  wire logic [15:0]      fac_gain_i,
	input  wire logic [15:0]      fac_offset_i,
	// Incoming pixels
	input  wire logic             frame_start_i,
	input  wire logic             pix_valid_i,
	input  wire logic [COL_W-1:0] pix_col_i,
	input  wire logic [PIX_W-1:0] pix_data_i,
	// Outgoing pixels
	output logic                  pix_valid_o,
	output logic [PIX_W-1:0]      pix_data_o
);

	localparam int NCOL = 1 << COL_W;
	localparam logic [PIX_W-1:0] PIX_MAX = '1;

	// Software settings
	logic             en_q;          // Enable as written
	corr_mode_t       mode_q;        // Selected mode
	logic [COL_W-1:0] col_idx_q;     // Table column index
	logic [IRQ_W-1:0] irq_stat_q;    // Sticky events
	logic [IRQ_W-1:0] irq_mask_q;    // Event mask
	// Settings latched at frame start
	logic             en_act_q;
	corr_mode_t       mode_act_q;
	logic [LVL_W-1:0] lvl_act_q;
	// User table and its retained copy
	logic [15:0]      ugain_q  [NCOL];
	logic [15:0]      uoff_q   [NCOL];
	logic [15:0]      sgain_q  [NCOL];
	logic [15:0]      soff_q   [NCOL];
	logic             saved_q;       // Retained copy holds data
	// Bus decode
	logic             setup;
	logic             wr;
	logic             calib;
	logic             err_q;         // Access refused, found at setup
	logic             save_pulse;
	logic             frame_ev;

	assign setup    = psel & ~penable;
	assign wr       = psel & penable & pwrite;
	assign calib    = (mode_q == MODE_CALIB);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & err_q;
	assign irq_o    = |(irq_stat_q & irq_mask_q);
	assign frame_ev = frame_start_i;
	assign save_pulse = wr & ~err_q & (paddr == CMD_OFS)
		& pwdata[CMD_SAVE_BIT];

	// Legality and read data worked out in setup, so both are flops
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			err_q  <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (setup)
		begin
			err_q  <= 1'b0;
			prdata <= 32'h0000_0000;
			case (paddr)
				CTRL_OFS:
				begin
					// Enable hidden while calibrating
					prdata[CTRL_EN_BIT] <= en_q & ~calib;
					prdata[CTRL_MODE_LSB +: 2] <= mode_q;
					// Mode code 3 does not exist
					if (pwrite && pwdata[CTRL_MODE_LSB +: 2] == 2'h3)
						err_q <= 1'b1;
				end
				STATE_OFS:
				begin
					prdata[0] <= en_act_q & (mode_act_q != MODE_CALIB);
					prdata[2:1] <= mode_act_q;
					prdata[3] <= saved_q;
					prdata[4 +: LVL_W] <= lvl_act_q;
				end
				COL_INDEX_OFS:
					prdata[COL_W-1:0] <= col_idx_q;
				GAIN_OFS:
				begin
					// Table only reachable in calibration
					err_q <= ~calib;
					if (calib)
						prdata[15:0] <= ugain_q[col_idx_q];
				end
				OFFSET_OFS:
				begin
					err_q <= ~calib
						| (pwrite & (pwdata[STEP_LOG-1:0] != '0));
					if (calib)
						prdata[15:0] <= uoff_q[col_idx_q];
				end
				STEP_OFS:
					prdata[15:0] <= OFFSET_STEP;
				CMD_OFS:
					err_q <= ~calib;
				IRQ_STAT_OFS:
					prdata[IRQ_W-1:0] <= irq_stat_q;
				IRQ_MASK_OFS:
					prdata[IRQ_W-1:0] <= irq_mask_q;
				// Unmapped address answers with an error
				default:
					err_q <= 1'b1;
			endcase
		end
	end

	// Enable and mode settings
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			en_q   <= EN_RST;
			mode_q <= MODE_FACTORY;
		end
		else if (wr && !err_q && paddr == CTRL_OFS)
		begin
			// Enable cannot be changed while calibrating
			if (!calib)
				en_q <= pwdata[CTRL_EN_BIT];
			mode_q <= corr_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
		end
	end

	// Column index, any width beyond the table is dropped
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			col_idx_q <= '0;
		else if (wr && paddr == COL_INDEX_OFS)
			col_idx_q <= pwdata[COL_W-1:0];
	end

	// User table: edits, reset command; defaults are identity
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < NCOL; i++)
			begin
				ugain_q[i] <= GAIN_UNITY;
				uoff_q[i]  <= OFFSET_NONE;
			end
		end
		else if (wr && !err_q)
		begin
			// err_q already refuses any table access outside calibration
			if (paddr == GAIN_OFS)
				ugain_q[col_idx_q] <= pwdata[15:0];
			else if (paddr == OFFSET_OFS)
				uoff_q[col_idx_q] <= pwdata[15:0];
			else if (paddr == CMD_OFS && pwdata[CMD_RESET_BIT])
			begin
				// Whole table restored in one cycle
				for (int i = 0; i < NCOL; i++)
				begin
					ugain_q[i] <= saved_q ? sgain_q[i] : GAIN_UNITY;
					uoff_q[i]  <= saved_q ? soff_q[i] : OFFSET_NONE;
				end
			end
		end
	end

	// Retained copy; not reset so it outlives a device reset
	always_ff @(posedge clock_i)
	begin
		if (save_pulse)
		begin
			// Overwrites the previous copy whole
			for (int i = 0; i < NCOL; i++)
			begin
				sgain_q[i] <= ugain_q[i];
				soff_q[i]  <= uoff_q[i];
			end
		end
	end

	// Marks that the retained copy holds data
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			saved_q <= 1'b0;
		else if (save_pulse)
			saved_q <= 1'b1;
	end

	// Interrupt mask
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			irq_mask_q <= '0;
		else if (wr && paddr == IRQ_MASK_OFS)
			irq_mask_q <= pwdata[IRQ_W-1:0];
	end

	// Sticky events; a new event wins over a clearing write
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			irq_stat_q <= '0;
		else
		begin
			for (int b = 0; b < IRQ_W; b++)
			begin
				if (wr && paddr == IRQ_STAT_OFS && pwdata[b])
					irq_stat_q[b] <= 1'b0;
			end
			if (frame_ev)
				irq_stat_q[IRQ_FRAME_BIT] <= 1'b1;
			if (wr && err_q)
				irq_stat_q[IRQ_ERR_BIT] <= 1'b1;
			if (save_pulse)
				irq_stat_q[IRQ_SAVE_BIT] <= 1'b1;
		end
	end

	// Settings take hold only at a frame start, never mid-frame
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			en_act_q   <= EN_RST;
			mode_act_q <= MODE_FACTORY;
			lvl_act_q  <= '0;
		end
		else if (frame_ev)
		begin
			en_act_q   <= en_q;
			mode_act_q <= mode_q;
			lvl_act_q  <= gain_level_i;
		end
	end

	// Coefficient choice for the arriving pixel
	logic        corr_on;    // Correction applies this frame
	logic [15:0] sel_gain;
	logic [15:0] sel_off;

	// Factory store looked up by column and latched gain level
	assign fac_col_o   = pix_col_i;
	assign fac_level_o = lvl_act_q;
	// Latched calibration forces bypass; edits made before the next frame start still reach user-mode pixels
	assign corr_on = en_act_q && (mode_act_q != MODE_CALIB);

	always_comb
	begin
		// Column alone picks the user entry; factory also uses level
		if (mode_act_q == MODE_USER)
		begin
			sel_gain = ugain_q[pix_col_i];
			sel_off  = uoff_q[pix_col_i];
		end
		else
		begin
			sel_gain = fac_gain_i;
			sel_off  = fac_offset_i;
		end
	end

	// Stage one: add offset and clamp
	logic signed [PIX_W+5:0] sum;
	logic [PIX_W-1:0]        sum_sat_q;
	logic [15:0]             gain_q;
	logic                    on_q;
	logic                    v1_q;
	logic [PIX_W-1:0]        raw_q;

	assign sum = $signed({6'h00, pix_data_i})
		+ PIX_W'(0) + (PIX_W+6)'($signed(sel_off));

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			v1_q      <= 1'b0;
			on_q      <= 1'b0;
			sum_sat_q <= '0;
			gain_q    <= '0;
			raw_q     <= '0;
		end
		else
		begin
			v1_q   <= pix_valid_i;
			on_q   <= corr_on;
			raw_q  <= pix_data_i;
			gain_q <= sel_gain;
			// Negative sums floor at black, overflow at full scale
			if (sum < 0)
				sum_sat_q <= '0;
			else if (sum > $signed({6'h00, PIX_MAX}))
				sum_sat_q <= PIX_MAX;
			else
				sum_sat_q <= sum[PIX_W-1:0];
		end
	end

	// Stage two: multiply by gain in fixed point
	logic [PIX_W+15:0] prod;
	logic [PIX_W+15:0] prod_sh;

	assign prod    = {16'h0000, sum_sat_q} * {{PIX_W{1'b0}}, gain_q};
	assign prod_sh = prod >> GAIN_FRAC;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pix_valid_o <= 1'b0;
			pix_data_o  <= '0;
		end
		else
		begin
			pix_valid_o <= v1_q;
			// Bypass rides the same two stages
			if (!on_q)
				pix_data_o <= raw_q;
			else if (prod_sh > {16'h0000, PIX_MAX})
				pix_data_o <= PIX_MAX;
			else
				pix_data_o <= prod_sh[PIX_W-1:0];
		end
	end

endmodule

// ===== dv/col_fix_factory.sv
`timescale 1ns/1ps
module col_fix_factory (
	// Lookup request
	input  wire logic [5:0]  col_i,
	input  wire logic [2:0]  level_i,
	// Coefficients, same cycle
	output logic      [15:0] gain_o,
	output logic      [15:0] offset_o
);
	// A quarter more gain per level, so each level owns a set
	assign gain_o = 16'h1000 + {3'h0, level_i, 10'h000};
	// Offset follows the column only
	assign offset_o = {10'h000, col_i};
endmodule

// ===== dv/col_fix_props.sv
`timescale 1ns/1ps
module col_fix_props
	import col_fix_pkg::*;
#(
	parameter int PIX_W = 12,
	parameter int COL_W = 6,
	parameter int LVL_W = 3
)(
	// Clock, reset, bus
	input wire logic             clock_i,
	input wire logic             rst_b_i,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [7:0]       paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             irq_o,
	// Pixel side
	input wire logic [LVL_W-1:0] gain_level_i,
	input wire logic [COL_W-1:0] fac_col_o,
	input wire logic [LVL_W-1:0] fac_level_o,
	input wire logic [15:0]      fac_gain_i,
	input wire logic [15:0]      fac_offset_i,
	input wire logic             frame_start_i,
	input wire logic             pix_valid_i,
	input wire logic [COL_W-1:0] pix_col_i,
	input wire logic [PIX_W-1:0] pix_data_i,
	input wire logic             pix_valid_o,
	input wire logic [PIX_W-1:0] pix_data_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	logic acc; // Access phase of a transfer
	assign acc = psel && penable;
	// Bypass and correction share one two-edge pipe
	a_pix_latency: assert property (pix_valid_i |-> ##2 pix_valid_o)
		else $error("pixel lost");
	a_out_origin: assert property (pix_valid_o |-> $past(pix_valid_i, 2))
		else $error("pixel from nowhere");
	// Lookup column tracks the pixel column
	a_col_lookup: assert property (fac_col_o == pix_col_i)
		else $error("lookup column wrong");
	a_step_read: assert property (acc && !pwrite && paddr == STEP_OFS
		|-> prdata == {16'h0000, OFFSET_STEP} && !pslverr)
		else $error("step size wrong");
	a_offset_refuse: assert property (acc && pwrite && paddr == OFFSET_OFS
		&& pwdata[4:0] != 5'h00 |-> pslverr)
		else $error("off-step offset taken");
	// Only three modes exist
	a_mode_refuse: assert property (acc && pwrite && paddr == CTRL_OFS
		&& pwdata[2:1] == 2'h3 |-> pslverr)
		else $error("fourth mode taken");
	// Level moves only at a frame start
	a_level_hold: assert property (!frame_start_i |=> $stable(fac_level_o))
		else $error("level moved mid frame");
	a_level_take: assert property (frame_start_i
		|=> fac_level_o == $past(gain_level_i))
		else $error("level not latched");
	// Enable never shows as set while calibrating
	a_cal_en_hidden: assert property (acc && !pwrite && paddr == CTRL_OFS
		&& prdata[2:1] == 2'h2 |-> !prdata[0])
		else $error("enable visible in calibration");
	// A refused gain access hands back no table data
	a_refuse_no_data: assert property (acc && paddr == GAIN_OFS && pslverr
		|-> prdata == 32'h0000_0000)
		else $error("refused table access leaked data");
endmodule

bind column_shading_fix col_fix_props #(
	.PIX_W(PIX_W),
	.COL_W(COL_W),
	.LVL_W(LVL_W)
) u_col_fix_props (
	.clock_i       (clock_i),
	.rst_b_i       (rst_b_i),
	.psel          (psel),
	.penable       (penable),
	.pwrite        (pwrite),
	.paddr         (paddr),
	.pwdata        (pwdata),
	.prdata        (prdata),
	.pready        (pready),
	.pslverr       (pslverr),
	.irq_o         (irq_o),
	.gain_level_i  (gain_level_i),
	.fac_col_o     (fac_col_o),
	.fac_level_o   (fac_level_o),
	.fac_gain_i    (fac_gain_i),
	.fac_offset_i  (fac_offset_i),
	.frame_start_i (frame_start_i),
	.pix_valid_i   (pix_valid_i),
	.pix_col_i     (pix_col_i),
	.pix_data_i    (pix_data_i),
	.pix_valid_o   (pix_valid_o),
	.pix_data_o    (pix_data_o)
);

// ===== dv/column_shading_fix_tb.sv
`timescale 1ns/1ps
module column_shading_fix_tb;
	import col_fix_pkg::*;
	// Bus and reset
	logic        clock_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq_o;
	// Pixel side
	logic [2:0]  gain_level_i = 3'h0;
	logic [5:0]  fac_col_o;
	logic [2:0]  fac_level_o;
	logic [15:0] fac_gain_i;
	logic [15:0] fac_offset_i;
	logic        frame_start_i = 1'b0;
	logic        pix_valid_i = 1'b0;
	logic [5:0]  pix_col_i = 6'h00;
	logic [11:0] pix_data_i = 12'h000;
	logic        pix_valid_o;
	logic [11:0] pix_data_o;
	// Tallies and last answer
	int          n_fail = 0;
	int          num_checks = 0;
	logic [31:0] rd;
	logic        er;
	// Factory rows: level, column, pixel in, pixel out
	logic [32:0] rows [4] = '{
		{3'h0, 6'h05, 12'h064, 12'h069},
		{3'h2, 6'h03, 12'h3E8, 12'h5E0},
		{3'h1, 6'h00, 12'hFFF, 12'hFFF},
		{3'h3, 6'h0A, 12'h000, 12'h011}};

	always #50 clock_i = ~clock_i;

	column_shading_fix u_column_shading_fix (.*);
	col_fix_factory u_col_fix_factory (
		.col_i(fac_col_o),
		.level_i(fac_level_o),
		.gain_o(fac_gain_i),
		.offset_o(fac_offset_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Held until the ready edge; answer taken at that edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do
			@(posedge clock_i);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic e);
		apb(1'b1, a, d);
		chk({31'h0, er}, {31'h0, e});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask

	// Optional frame start, then one pixel seen two edges on
	task automatic pix_go(input logic [32:0] r, input logic fs);
		@(posedge clock_i);
		frame_start_i <= fs;
		gain_level_i <= r[32:30];
		@(posedge clock_i);
		frame_start_i <= 1'b0;
		pix_valid_i <= 1'b1;
		pix_col_i <= r[29:24];
		pix_data_i <= r[23:12];
		@(posedge clock_i);
		pix_valid_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		chk({31'h0, pix_valid_o}, 32'h1);
		chk({20'h0, pix_data_o}, {20'h0, r[11:0]});
	endtask

	// Normal case: the pixel opens a new frame
	task automatic pix(input logic [32:0] r);
		pix_go(r, 1'b1);
	endtask

	task automatic do_reset();
		rst_b_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1'b1;
	endtask

	task automatic print_verdict();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Whole run is under two hundred cycles
	initial
	begin
		#400000;
		n_fail++;
		print_verdict();
	end

	initial
	begin
		do_reset();
		rdc(CTRL_OFS, 32'h1);
		rdc(STEP_OFS, 32'h20);
		foreach (rows[i])
			pix(rows[i]);
		wr(CTRL_OFS, 32'h0, 1'b0);
		// Mid frame: old enable and old level still rule
		pix_go({3'h0, 6'h05, 12'h064, 12'h0B7}, 1'b0);
		pix({3'h0, 6'h05, 12'h064, 12'h064});
		wr(CTRL_OFS, 32'h6, 1'b1);
		wr(GAIN_OFS, 32'h2000, 1'b1);
		wr(CTRL_OFS, 32'h5, 1'b0);
		rdc(CTRL_OFS, 32'h4);
		wr(COL_INDEX_OFS, 32'h7, 1'b0);
		wr(GAIN_OFS, 32'h2000, 1'b0);
		wr(OFFSET_OFS, 32'h21, 1'b1);
		wr(OFFSET_OFS, 32'h40, 1'b0);
		rdc(OFFSET_OFS, 32'h40);
		pix({3'h0, 6'h07, 12'h064, 12'h064});
		wr(CMD_OFS, 32'h2, 1'b0);
		rdc(IRQ_STAT_OFS, 32'h7);
		wr(GAIN_OFS, 32'h3000, 1'b0);
		wr(CMD_OFS, 32'h1, 1'b0);
		rdc(GAIN_OFS, 32'h2000);
		// Leave calibration with no pixel streaming
		wr(CTRL_OFS, 32'h3, 1'b0);
		pix({3'h5, 6'h07, 12'h064, 12'h148});
		rdc(STATE_OFS, 32'h5B);
		pix({3'h2, 6'h08, 12'h064, 12'h064});
		wr(GAIN_OFS, 32'h1, 1'b1);
		chk({31'h0, irq_o}, 32'h0);
		wr(IRQ_MASK_OFS, 32'h2, 1'b0);
		rdc(IRQ_MASK_OFS, 32'h2);
		@(posedge clock_i);
		chk({31'h0, irq_o}, 32'h1);
		wr(IRQ_STAT_OFS, 32'h2, 1'b0);
		@(posedge clock_i);
		chk({31'h0, irq_o}, 32'h0);
		wr(8'h40, 32'h0, 1'b1);
		do_reset();
		rdc(CTRL_OFS, 32'h1);
		rdc(STATE_OFS, 32'h1);
		// Nothing saved since reset: table reset gives defaults
		wr(CTRL_OFS, 32'h4, 1'b0);
		wr(GAIN_OFS, 32'h2000, 1'b0);
		wr(CMD_OFS, 32'h1, 1'b0);
		rdc(GAIN_OFS, 32'h1000);
		print_verdict();
	end
endmodule
